// ---- rtl/ipa_regs_map.vh ----
// Register map constants for the init, power profile and alarm block
// Summary of operation
// - Startup status bit 0 reads 1 after initialization completes; others zero.
// - Profile word a: 0x06 low power, 0x0F high performance, reset 0x0F.
// - Profile word b: 0x00 low power, 0x04 high performance, reset 0x04.
// - Profile word c: 0x14 low power, 0x1B high performance, reset 0x1B.
// - Summary bit 0 reads 1 when any unmasked alarm flag is set.
// - A per-alarm mask excludes individual flags from the summary.
// - Summary alarm drives calibration status pin when source select chooses it.
// - Lane buffer fault flag, bit 5, sets on any lane FIFO fault.
// - Writing 1 to the lane buffer fault flag clears it.
// - A per-lane fault register records which lane faulted.
// - Alarm status resets to 0x3F with documented bit layout.
// - Serdes PLL unlock flag sets while PLL unlocked; write 1 clears.
// - Link state fault flag sets on enabled link not in data state, or on link realign.
// - Clock realign flag sets when SYSREF realigns internal clocks.
// - Divider mismatch flag sets when channel dividers disagree.
`ifndef IPA_REGS_MAP_VH
`define IPA_REGS_MAP_VH

`define IPA_ADDR_W          12
`define IPA_OFS_INIT        12'h270
`define IPA_OFS_PROF_A      12'h29A
`define IPA_OFS_PROF_B      12'h29B
`define IPA_OFS_PROF_C      12'h29C
`define IPA_OFS_SUMMARY     12'h2C0
`define IPA_OFS_ALARM       12'h2C1
`define IPA_OFS_MASK        12'h2C2
`define IPA_OFS_LANE        12'h2C4

`define IPA_RST_PROF_A      8'h0F
`define IPA_RST_PROF_B      8'h04
`define IPA_RST_PROF_C      8'h1B
`define IPA_RST_ALARM       6'h3F
`define IPA_RST_MASK        8'h3F
`define IPA_RST_LANE        8'hFF

`define IPA_LP_A            8'h06
`define IPA_LP_B            8'h00
`define IPA_LP_C            8'h14

`define IPA_BIT_DIVIDER     0
`define IPA_BIT_RSVD        1
`define IPA_BIT_REALIGN     2
`define IPA_BIT_LINK        3
`define IPA_BIT_PLL         4
`define IPA_BIT_LANE        5
`define IPA_ALARM_W         6
`define IPA_LANES           8

`define IPA_MODE_HP         2'h0
`define IPA_MODE_LP         2'h1
`define IPA_MODE_RSVD       2'h2
`define IPA_MODE_MIXED      2'h3

`endif

// ---- rtl/ipa_event_flag.v ----
// One write-one-to-clear sticky alarm flag
`timescale 1ns/10ps
`default_nettype none
module ipa_event_flag (
  input  wire sys_clk,
  input  wire rst_n,
  input  wire setEvent,
  input  wire clearWr,
  output reg  flag_r
);
  // Set beats clear so a same-cycle event is kept
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b1;
    end else if (setEvent) begin
      flag_r <= 1'b1;
    end else if (clearWr) begin
      flag_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ipa_profile_decode.v ----
// Decodes the three power profile codes into an operating mode
`timescale 1ns/10ps
`default_nettype none
`include "ipa_regs_map.vh"
module ipa_profile_decode (
  input  wire [7:0] codeA,
  input  wire [7:0] codeB,
  input  wire [7:0] codeC,
  output reg  [1:0] modeSel
);
  reg lpA;
  reg lpB;
  reg lpC;
  reg hpA;
  reg hpB;
  reg hpC;
  always @* begin
    lpA = (codeA == `IPA_LP_A);
    hpA = (codeA == `IPA_RST_PROF_A);
    lpB = (codeB == `IPA_LP_B);
    hpB = (codeB == `IPA_RST_PROF_B);
    lpC = (codeC == `IPA_LP_C);
    hpC = (codeC == `IPA_RST_PROF_C);
    if (lpA && lpB && lpC) begin
      modeSel = `IPA_MODE_LP;
    end else if (hpA && hpB && hpC) begin
      modeSel = `IPA_MODE_HP;
    end else if ((lpA || hpA) && (lpB || hpB) && (lpC || hpC)) begin
      // Legal codes but mixed modes, which the host must avoid
      modeSel = `IPA_MODE_MIXED;
    end else begin
      modeSel = `IPA_MODE_RSVD;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ipa_regs.v ----
// Init status, power profile and alarm register bank
`timescale 1ns/10ps
`default_nettype none
`include "ipa_regs_map.vh"
module ipa_regs (
  input  wire                   sys_clk,
  input  wire                   rst_n,
  input  wire                   regWrite,
  input  wire                   regRead,
  input  wire [`IPA_ADDR_W-1:0] regAddr,
  input  wire [7:0]             regWrData,
  output reg  [7:0]             regRdData,
  input  wire                   initSeqDone,
  input  wire [`IPA_LANES-1:0]  laneFifoFault,
  input  wire                   serdesPllLocked,
  input  wire                   linkEnabled,
  input  wire                   linkInDataState,
  input  wire                   linkRealign,
  input  wire                   sysrefRealign,
  input  wire                   dividerMismatch,
  input  wire                   statusPinSelAlarm,
  input  wire                   calStatusIn,
  output wire                   calibration_status_pin,
  output reg                    alarmSummary_r,
  output reg  [7:0]             power_profile_code_a,
  output reg  [7:0]             power_profile_code_b,
  output reg  [7:0]             power_profile_code_c,
  output wire [1:0]             powerMode
);
  reg                    initDone_r;
  reg  [7:0]             alarm_mask_register;
  reg  [`IPA_LANES-1:0]  per_lane_buffer_fault;
  wire [`IPA_ALARM_W-1:0] alarmFlags;
  wire [`IPA_ALARM_W-1:0] alarmSet;
  wire                   wrAlarm;
  reg  [7:0]             rdData_nxt;

  function isAddr;
    input [`IPA_ADDR_W-1:0] a;
    input [`IPA_ADDR_W-1:0] ofs;
    begin
      isAddr = (a == ofs);
    end
  endfunction

  assign wrAlarm = regWrite && isAddr(regAddr, `IPA_OFS_ALARM);

  // Status is a level, caught once the sequencer finishes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      initDone_r <= 1'b0;
    end else if (initSeqDone) begin
      initDone_r <= 1'b1;
    end
  end

  // Host writes are taken as given; restart ordering is the host's job
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_profile_code_a <= `IPA_RST_PROF_A;
      power_profile_code_b <= `IPA_RST_PROF_B;
      power_profile_code_c <= `IPA_RST_PROF_C;
      alarm_mask_register  <= `IPA_RST_MASK;
    end else if (regWrite) begin
      if (isAddr(regAddr, `IPA_OFS_PROF_A)) begin
        power_profile_code_a <= regWrData;
      end
      if (isAddr(regAddr, `IPA_OFS_PROF_B)) begin
        power_profile_code_b <= regWrData;
      end
      if (isAddr(regAddr, `IPA_OFS_PROF_C)) begin
        power_profile_code_c <= regWrData;
      end
      if (isAddr(regAddr, `IPA_OFS_MASK)) begin
        alarm_mask_register <= regWrData;
      end
    end
  end

  ipa_profile_decode uDecode (
    .codeA   (power_profile_code_a),
    .codeB   (power_profile_code_b),
    .codeC   (power_profile_code_c),
    .modeSel (powerMode)
  );

  assign alarmSet[`IPA_BIT_DIVIDER] = dividerMismatch;
  assign alarmSet[`IPA_BIT_RSVD]    = 1'b0;
  assign alarmSet[`IPA_BIT_REALIGN] = sysrefRealign;
  assign alarmSet[`IPA_BIT_LINK]    =
    (linkEnabled && !linkInDataState) || linkRealign;
  assign alarmSet[`IPA_BIT_PLL]     = !serdesPllLocked;
  assign alarmSet[`IPA_BIT_LANE]    = |laneFifoFault;

  genvar gi;
  generate
    for (gi = 0; gi < `IPA_ALARM_W; gi = gi + 1) begin : gFlag
      ipa_event_flag uFlag (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .setEvent (alarmSet[gi]),
        .clearWr  (wrAlarm && regWrData[gi]),
        .flag_r   (alarmFlags[gi])
      );
    end
  endgenerate

  // Per-lane record, same write-one-to-clear manner as the flags
  generate
    for (gi = 0; gi < `IPA_LANES; gi = gi + 1) begin : gLane
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          per_lane_buffer_fault[gi] <= 1'b1;
        end else if (laneFifoFault[gi]) begin
          per_lane_buffer_fault[gi] <= 1'b1;
        end else if (regWrite && isAddr(regAddr, `IPA_OFS_LANE) &&
                     regWrData[gi]) begin
          per_lane_buffer_fault[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Registered so the pin never glitches; costs one clock of latency
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmSummary_r <= 1'b0;
    end else begin
      alarmSummary_r <=
        |(alarmFlags & ~alarm_mask_register[`IPA_ALARM_W-1:0]);
    end
  end

  assign calibration_status_pin =
    statusPinSelAlarm ? alarmSummary_r : calStatusIn;

  always @* begin
    rdData_nxt = 8'h00;
    case (regAddr)
      `IPA_OFS_INIT:    rdData_nxt = {7'h00, initDone_r};
      `IPA_OFS_PROF_A:  rdData_nxt = power_profile_code_a;
      `IPA_OFS_PROF_B:  rdData_nxt = power_profile_code_b;
      `IPA_OFS_PROF_C:  rdData_nxt = power_profile_code_c;
      `IPA_OFS_SUMMARY: rdData_nxt = {7'h00, alarmSummary_r};
      `IPA_OFS_ALARM:   rdData_nxt = {2'h0, alarmFlags};
      `IPA_OFS_MASK:    rdData_nxt = alarm_mask_register;
      `IPA_OFS_LANE:    rdData_nxt = per_lane_buffer_fault;
      default:          rdData_nxt = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= rdData_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- tb/ipa_regs_chk.sv ----
// Port assertions for the init, profile and alarm register bank
`timescale 1ns/10ps
`default_nettype none
module ipa_regs_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [11:0] regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        initSeqDone,
  input wire logic [7:0]  laneFifoFault,
  input wire logic        statusPinSelAlarm,
  input wire logic        calStatusIn,
  input wire logic        calibration_status_pin,
  input wire logic        alarmSummary_r,
  input wire logic [7:0]  power_profile_code_a
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Guard on the previous edge keeps stale pre-reset samples out
  sequence r(a, c);
    c && $past(rst_n) && regRead && regAddr == a;
  endsequence
  a_init_done: assert property (r(12'h270, $past(initSeqDone)) |=>
    regRdData == 8'h01) else $error("init status read wrong");
  a_lane_flag: assert property (r(12'h2C1, $past(|laneFifoFault)) |=>
    regRdData[5]) else $error("lane fault flag missing");
  a_resv_zero: assert property (r(12'h2C1, 1'h1) |=>
    regRdData[7:6] == 2'h0) else $error("alarm upper bits set");
  a_summary_upper: assert property (r(12'h2C0, 1'h1) |=>
    regRdData[7:1] == 7'h00) else $error("summary upper bits set");
  a_unmapped_zero: assert property (r(12'h300, 1'h1) |=>
    regRdData == 8'h00) else $error("unmapped read not zero");
  a_prof_write: assert property (regWrite && regAddr == 12'h29A |=>
    power_profile_code_a == $past(regWrData)) else $error("profile write lost");
  a_prof_read: assert property (r(12'h29A, 1'h1) |=>
    regRdData == $past(power_profile_code_a)) else $error("profile read");
  a_pin_mux: assert property (calibration_status_pin ==
    (statusPinSelAlarm ? alarmSummary_r : calStatusIn)) else $error("pin mux");
  a_rdata_hold: assert property (!regRead |=>
    $stable(regRdData)) else $error("read data moved without read");
endmodule
bind ipa_regs ipa_regs_chk i_chk (.sys_clk, .rst_n, .regWrite, .regRead,
  .regAddr, .regWrData, .regRdData, .initSeqDone, .laneFifoFault,
  .statusPinSelAlarm, .calStatusIn, .calibration_status_pin, .alarmSummary_r,
  .power_profile_code_a);
`default_nettype wire

// ---- tb/ipa_host.sv ----
// Host model driving the register strobes of the bank
`timescale 1ns/10ps
`default_nettype none
module ipa_host (
  input  wire logic        sys_clk,
  output var  logic        regWrite,
  output var  logic        regRead,
  output var  logic [11:0] regAddr,
  output var  logic [7:0]  regWrData,
  input  wire logic [7:0]  regRdData,
  output var  logic        linkEnabled
);
  logic [7:0] d;
  logic       calEnable = 1'h0;
  initial {regWrite, regRead, linkEnabled, regAddr, regWrData} = 23'h000000;
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    regAddr = a;
    regWrData = v;
    regWrite = 1'h1;
    @(posedge sys_clk) #1;
    regWrite = 1'h0;
    regWrData = ~v;
    // Idle edge keeps strobes apart and lets the summary settle
    @(posedge sys_clk) #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    regAddr = a;
    regRead = 1'h1;
    @(posedge sys_clk) #1;
    regRead = 1'h0;
    @(posedge sys_clk) #1;
    v = regRdData;
  endtask
  // Only status polls go out until init reads done
  task automatic waitInit();
    do rd(12'h270, d);
    while (d[0] !== 1'h1);
  endtask
  // Rate assumed low enough for low power; link off, all words together
  task automatic prof(input logic [7:0] a, b, c);
    linkEnabled = 1'h0;
    calEnable = 1'h0;
    wr(12'h29A, a);
    wr(12'h29B, b);
    wr(12'h29C, c);
    // Results only trusted after recalibrating in the new mode
    calEnable = 1'h1;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench for the init, profile and alarm register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic             sys_clk = 1'h0;
  logic             rst_n = 1'h0;
  logic             initSeqDone = 1'h0;
  logic             statusPinSelAlarm = 1'h1;
  logic             calStatusIn = 1'h0;
  logic [7:0]       laneFifoFault = 8'h00;
  logic [4:0]       ev = 5'h00;
  logic [7:0]       d;
  logic [7:0]       evBit [5] = '{8'h10, 8'h08, 8'h08, 8'h04, 8'h01};
  wire logic        regWrite, regRead, linkEnabled, pin;
  wire logic [11:0] regAddr;
  wire logic [7:0]  regWrData, regRdData;
  wire logic [1:0]  powerMode;
  int               err_count = 0;
  int               checks = 0;
  always #4 sys_clk = ~sys_clk;
  ipa_host i_host (.sys_clk, .regWrite, .regRead, .regAddr, .regWrData,
    .regRdData, .linkEnabled);
  ipa_regs i_dut (.sys_clk, .rst_n, .regWrite, .regRead, .regAddr, .regWrData,
    .regRdData, .initSeqDone, .laneFifoFault, .serdesPllLocked(~ev[0]),
    .linkEnabled, .linkInDataState(~ev[1]), .linkRealign(ev[2]),
    .sysrefRealign(ev[3]), .dividerMismatch(ev[4]), .statusPinSelAlarm,
    .calStatusIn, .calibration_status_pin(pin), .alarmSummary_r(),
    .power_profile_code_a(), .power_profile_code_b(),
    .power_profile_code_c(), .powerMode);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] exp);
    i_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'h1;
    @(posedge sys_clk) #1;
    rc(12'h270, 8'h00);
    initSeqDone = 1'h1;
    i_host.waitInit();
    rc(12'h29A, 8'h0F);
    rc(12'h29B, 8'h04);
    rc(12'h29C, 8'h1B);
    chk({6'h00, powerMode}, 8'h00);
    rc(12'h2C1, 8'h3F);
    rc(12'h2C0, 8'h00);
    i_host.wr(12'h2C2, 8'h00);
    rc(12'h2C0, 8'h01);
    chk({7'h00, pin}, 8'h01);
    statusPinSelAlarm = 1'h0;
    @(posedge sys_clk) #1 chk({7'h00, pin}, 8'h00);
    i_host.linkEnabled = 1'h1;
    i_host.wr(12'h2C1, 8'h3F);
    rc(12'h2C1, 8'h00);
    rc(12'h2C0, 8'h00);
    i_host.wr(12'h270, 8'hFF);
    rc(12'h270, 8'h01);
    rc(12'h300, 8'h00);
    for (int i = 0; i < 5; i++) begin
      ev[i] = 1'h1;
      @(posedge sys_clk) #1 ev[i] = 1'h0;
      rc(12'h2C1, evBit[i]);
      rc(12'h2C0, 8'h01);
      i_host.wr(12'h2C1, evBit[i]);
    end
    i_host.wr(12'h2C4, 8'hFF);
    laneFifoFault = 8'h04;
    @(posedge sys_clk) #1 laneFifoFault = 8'h00;
    rc(12'h2C1, 8'h20);
    rc(12'h2C4, 8'h04);
    i_host.wr(12'h2C2, 8'h20);
    rc(12'h2C0, 8'h00);
    i_host.wr(12'h2C1, 8'h20);
    rc(12'h2C1, 8'h00);
    i_host.prof(8'h06, 8'h00, 8'h14);
    chk({6'h00, powerMode}, 8'h01);
    rc(12'h29C, 8'h14);
    i_host.wr(12'h29A, 8'h07);
    chk({6'h00, powerMode}, 8'h02);
    i_host.prof(8'h0F, 8'h04, 8'h1B);
    chk({6'h00, powerMode}, 8'h00);
    i_host.wr(12'h29A, 8'h06);
    chk({6'h00, powerMode}, 8'h03);
    stop_test();
  end
endmodule
`default_nettype wire
